// ==== design/parallel_program_interface.sv ====
/*
 * Parallel programming front end: command / address / data latches,
 * Flash and EEPROM arrays, chip erase, protection bits, fuses and
 * identification bytes. Assumes the programmer holds data and selects
 * stable around each strobe edge, for at least three clock cycles.
 */
// Operation
// - Load pulse rising edge loads address, data or command per action bits; 11 idles.
// - Command 80 chip erase, 10 Flash write, 11 EEPROM write.
// - Command 08 signature read, 02 Flash read, 03 EEPROM read; command steers strobes.
// - Command 40 fuse write, 20 protection write, 04 fuse and protection read.
// - Byte select picks low (0) or high (1) byte for loads, writes, reads.
// - Ready output low while a byte programs, high when ready.
// - Data bus driven only while output strobe is low.
// - Write strobe low pulse starts byte programming and drops ready.
// - Command and address stay latched through programming.
// - Chip erase clears memories, and protection bits on the same edge as the last Flash word; fuses untouched.
// - Chip erase shows no ready activity; precedes reprogramming.
// - Protection bits cleared only by chip erase; both 1 means unprotected.
// - First bit 0, second 1: Flash and EEPROM programming refused.
// - Both bits 0: programming and verify reads refused.
// - Active protection also refuses fuse writes.
// - Serial download fuse 0 enables serial download; fuses not serially reachable.
// - Oscillator fuse 0 selects internal RC clock; default 1.
// - Three identification bytes at addresses 0 to 2, own address space.
// - Protection mode 3 serial identification reads return the address.
// - Memories programmed one byte at a time.
// - Flash read gives low byte with select 0, high byte with 1.
// - Fuse byte bit 5 serial fuse, bit 0 oscillator fuse.
`default_nettype none
module parallel_program_interface
   import parallel_program_pkg::*;
#(
   parameter int FLASH_WORDS = 512,
   parameter int EE_BYTES    = 64
) (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_b_i,
   // Programming pins
   input  wire logic       prog_entry_i,
   input  wire logic       load_pulse_pin_i,
   input  wire logic       action_select_lo_i,
   input  wire logic       action_select_hi_i,
   input  wire logic       byte_half_select_i,
   input  wire logic       write_strobe_b_i,
   input  wire logic       output_strobe_b_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o,
   output logic            data_oe_o,
   output logic            prog_done_indicator_o,
   // Serial identification read port
   input  wire logic [1:0] serial_sig_addr_i,
   output logic      [7:0] serial_sig_data_o,
   // Fuse and protection state
   output logic            serial_download_fuse_o,
   output logic            internal_osc_fuse_o,
   output logic            protect_bit_one_o,
   output logic            protect_bit_two_o
);
   // Index paths are cut from two address bytes, so sizes beyond them are refused
   if (FLASH_WORDS < 2 || FLASH_WORDS > 65536 || EE_BYTES < 1 || EE_BYTES > 256 ||
       EE_BYTES > FLASH_WORDS) begin : g_size_check
      $error("parallel_program_interface: unsupported array size");
   end

   localparam int FA_W = $clog2(FLASH_WORDS);
   localparam int EA_W = (EE_BYTES > 1) ? $clog2(EE_BYTES) : 1;

   logic [1:0]           rst_sync;
   logic                 rst_n;
   logic [2:0]           pin_s1;
   logic [2:0]           pin_s2;
   logic [2:0]           pin_d;
   logic                 load_rise;
   logic                 wr_fall;
   logic                 oe_low;
   logic [7:0]           cmd;
   logic [7:0]           addr_lo;
   logic [7:0]           addr_hi;
   logic [7:0]           data_lo;
   logic [7:0]           data_hi;
   prog_state_type       state;
   logic [PROG_CNT_W-1:0] prog_cnt;
   logic [FA_W-1:0]      erase_idx;
   logic [15:0]          flash_mem [FLASH_WORDS];
   logic [7:0]           ee_mem [EE_BYTES];
   logic [FA_W-1:0]      flash_idx;
   logic [EA_W-1:0]      ee_idx;
   logic                 prog_locked;
   logic                 verify_locked;
   logic                 mem_write;
   logic [7:0]           read_byte;
   logic [7:0]           sig_byte;

   // Reset release through two flops
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rst_sync <= 2'h0;
      else          rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Strobe synchronisers: {load, write_b, output_b}
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 3'h3;
         pin_s2 <= 3'h3;
         pin_d  <= 3'h3;
      end else begin
         pin_s1 <= {load_pulse_pin_i, write_strobe_b_i, output_strobe_b_i};
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2;
      end
   end
   // Pin state is ignored outside programming mode
   assign load_rise = prog_entry_i & pin_s2[2] & ~pin_d[2];
   assign wr_fall   = prog_entry_i & ~pin_s2[1] & pin_d[1];
   assign oe_low    = prog_entry_i & ~pin_s2[0];

   assign flash_idx     = FA_W'({addr_hi, addr_lo});
   assign ee_idx        = EA_W'(addr_lo);
   assign prog_locked   = ~protect_bit_one_o;
   assign verify_locked = ~protect_bit_one_o & ~protect_bit_two_o;
   assign mem_write     = wr_fall & (state == ST_IDLE) & ~prog_locked &
                          (cmd == CMD_FLASH_WR || cmd == CMD_EE_WR);

   // Latches hold across programming; only a load edge changes them
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd     <= CMD_RST;
         addr_lo <= 8'h00;
         addr_hi <= 8'h00;
         data_lo <= ERASED_BYTE;
         data_hi <= ERASED_BYTE;
      end else if (load_rise) begin
         case ({action_select_hi_i, action_select_lo_i})
            ACT_ADDR: begin
               if (byte_half_select_i) addr_hi <= data_i;
               else                    addr_lo <= data_i;
            end
            ACT_DATA: begin
               if (byte_half_select_i) data_hi <= data_i;
               else                    data_lo <= data_i;
            end
            ACT_CMD: cmd <= data_i;
            default: ;
         endcase
      end
   end

   // Sequencer: byte programming shows busy, erase does not
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         prog_cnt  <= '0;
         erase_idx <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wr_fall && cmd == CMD_CHIP_ERASE) begin
                  state     <= ST_ERASE;
                  erase_idx <= '0;
               end else if (mem_write) begin
                  state    <= ST_BUSY;
                  prog_cnt <= PROG_CNT_W'(PROG_CYCLES - 1);
               end
            end
            ST_BUSY: begin
               if (prog_cnt == '0) state <= ST_IDLE;
               else                prog_cnt <= prog_cnt - 1'b1;
            end
            ST_ERASE: begin
               if (erase_idx == FA_W'(FLASH_WORDS - 1)) state <= ST_IDLE;
               else                                    erase_idx <= erase_idx + 1'b1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Arrays carry no reset, as in a real nonvolatile store
   always_ff @(posedge core_clk_i) begin
      if (state == ST_ERASE) begin
         flash_mem[erase_idx] <= {ERASED_BYTE, ERASED_BYTE};
         if (erase_idx < FA_W'(EE_BYTES)) ee_mem[EA_W'(erase_idx)] <= ERASED_BYTE;
      end else if (mem_write) begin
         if (cmd == CMD_EE_WR) ee_mem[ee_idx] <= data_lo;
         else if (byte_half_select_i) flash_mem[flash_idx][15:8] <= data_hi;
         else flash_mem[flash_idx][7:0] <= data_lo;
      end
   end

   // Fuses and protection bits
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         serial_download_fuse_o <= SERIAL_FUSE_RST;
         internal_osc_fuse_o    <= OSC_FUSE_RST;
         protect_bit_one_o      <= PROT_RST;
         protect_bit_two_o      <= PROT_RST;
      end else if (state == ST_ERASE && erase_idx == FA_W'(FLASH_WORDS - 1)) begin
         protect_bit_one_o <= 1'b1;
         protect_bit_two_o <= 1'b1;
      end else if (wr_fall && state == ST_IDLE) begin
         if (cmd == CMD_FUSE_WR && !prog_locked) begin
            serial_download_fuse_o <= data_lo[SERIAL_FUSE_POS];
            internal_osc_fuse_o    <= data_lo[OSC_FUSE_POS];
         end else if (cmd == CMD_PROT_WR) begin
            // Programming can only take a bit from 1 to 0
            protect_bit_one_o <= protect_bit_one_o & data_lo[PROT_ONE_POS];
            protect_bit_two_o <= protect_bit_two_o & data_lo[PROT_TWO_POS];
         end
      end
   end

   always_comb begin
      case (addr_lo)
         8'h00:   sig_byte = SIG_BYTE0;
         8'h01:   sig_byte = SIG_BYTE1;
         8'h02:   sig_byte = SIG_BYTE2;
         default: sig_byte = ERASED_BYTE;
      endcase
   end

   always_comb begin
      read_byte = ERASED_BYTE;
      case (cmd)
         CMD_FLASH_RD: begin
            if (!verify_locked)
               read_byte = byte_half_select_i ? flash_mem[flash_idx][15:8] : flash_mem[flash_idx][7:0];
         end
         CMD_EE_RD: begin
            if (!verify_locked) read_byte = ee_mem[ee_idx];
         end
         CMD_SIG_RD: read_byte = sig_byte;
         CMD_FUSE_RD: begin
            read_byte                  = ERASED_BYTE;
            read_byte[SERIAL_FUSE_POS] = serial_download_fuse_o;
            read_byte[OSC_FUSE_POS]    = internal_osc_fuse_o;
            read_byte[PROT_ONE_POS]    = protect_bit_one_o;
            read_byte[PROT_TWO_POS]    = protect_bit_two_o;
         end
         default: read_byte = ERASED_BYTE;
      endcase
   end

   // Pin outputs
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         data_o                <= 8'h00;
         data_oe_o             <= 1'b0;
         prog_done_indicator_o <= 1'b1;
         serial_sig_data_o     <= 8'h00;
      end else begin
         data_oe_o             <= oe_low;
         data_o                <= oe_low ? read_byte : 8'h00;
         prog_done_indicator_o <= ~(mem_write | (state == ST_BUSY && prog_cnt != '0));
         // Fuses never appear on the serial side
         case (serial_sig_addr_i)
            2'h0:    serial_sig_data_o <= verify_locked ? 8'h00 : SIG_BYTE0;
            2'h1:    serial_sig_data_o <= verify_locked ? 8'h01 : SIG_BYTE1;
            2'h2:    serial_sig_data_o <= verify_locked ? 8'h02 : SIG_BYTE2;
            default: serial_sig_data_o <= ERASED_BYTE;
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n);

   a_cmd_load: assert property (load_rise && {action_select_hi_i, action_select_lo_i} == ACT_CMD
                                |=> cmd == $past(data_i)) else $error("command byte not loaded");
   a_idle_load: assert property (load_rise && {action_select_hi_i, action_select_lo_i} == 2'h3
                                 |=> $stable(cmd) && $stable(addr_lo) && $stable(data_lo))
      else $error("idle action changed a latch");
   a_busy_drop: assert property (mem_write |=> !prog_done_indicator_o [*2])
      else $error("ready did not drop on byte write");
   a_busy_end: assert property ($fell(prog_done_indicator_o) |-> ##[1:300] prog_done_indicator_o)
      else $error("ready stuck low");
   a_erase_quiet: assert property (state == ST_ERASE |=> prog_done_indicator_o)
      else $error("erase showed busy");
   a_oe_drive: assert property (data_oe_o |-> $past(oe_low))
      else $error("bus driven without output strobe");
   a_lock_refuse: assert property (wr_fall && prog_locked && cmd == CMD_FLASH_WR |=> ##1 prog_done_indicator_o
                                   && state == ST_IDLE) else $error("locked write was accepted");
   a_verify_block: assert property (oe_low && verify_locked && cmd == CMD_FLASH_RD |=> data_o == ERASED_BYTE)
      else $error("verify read not blocked");
   a_prot_rise: assert property ($rose(protect_bit_one_o) |-> $past(state) == ST_ERASE)
      else $error("protection cleared without erase");
   a_fuse_block: assert property (wr_fall && prog_locked && cmd == CMD_FUSE_WR |=> $stable(internal_osc_fuse_o)
                                  && $stable(serial_download_fuse_o)) else $error("fuse written while locked");
   a_sig_mask: assert property (verify_locked && serial_sig_addr_i == 2'h1 |=> serial_sig_data_o == 8'h01)
      else $error("serial signature not masked");

   c_erase: cover property (state == ST_ERASE ##1 state == ST_IDLE);
   c_flash_write: cover property (mem_write && cmd == CMD_FLASH_WR && byte_half_select_i);
   c_flash_read: cover property (data_oe_o && cmd == CMD_FLASH_RD && !verify_locked);
   c_locked: cover property (verify_locked && wr_fall);
endmodule
`default_nettype wire

// ==== design/parallel_program_pkg.sv ====
/*
 * Constants for the parallel programming front end: command codes,
 * action codes, fuse and protection bit positions, timing counts.
 * Assumes a 200 MHz core clock.
 */
`default_nettype none
package parallel_program_pkg;
   // Load pulse actions {hi, lo}
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD  = 2'h2;
   // Command bytes
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
   localparam logic [7:0] CMD_FUSE_WR    = 8'h40;
   localparam logic [7:0] CMD_PROT_WR    = 8'h20;
   localparam logic [7:0] CMD_FLASH_WR   = 8'h10;
   localparam logic [7:0] CMD_EE_WR      = 8'h11;
   localparam logic [7:0] CMD_SIG_RD     = 8'h08;
   localparam logic [7:0] CMD_FUSE_RD    = 8'h04;
   localparam logic [7:0] CMD_FLASH_RD   = 8'h02;
   localparam logic [7:0] CMD_EE_RD      = 8'h03;
   // Field positions in the fuse / protection byte
   localparam int SERIAL_FUSE_POS = 5;
   localparam int OSC_FUSE_POS    = 0;
   localparam int PROT_ONE_POS    = 1;
   localparam int PROT_TWO_POS    = 2;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // Reset values
   localparam logic SERIAL_FUSE_RST = 1'b0;
   localparam logic OSC_FUSE_RST    = 1'b1;
   localparam logic PROT_RST        = 1'b1;
   localparam logic [7:0] CMD_RST   = 8'h00;
   // Identification bytes: values arbitrary
   localparam logic [7:0] SIG_BYTE0 = 8'h5A;
   localparam logic [7:0] SIG_BYTE1 = 8'h3C;
   localparam logic [7:0] SIG_BYTE2 = 8'h0F;
   // Byte programming time
   localparam int CLK_PERIOD_PS = 5000;
   localparam int PROG_TIME_NS  = 1000;
   localparam int PROG_CYCLES   = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PROG_CNT_W    = 9;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_BUSY,
      ST_ERASE
   } prog_state_type;
endpackage
`default_nettype wire

// ==== verification/parallel_program_interface_tb.sv ====
/*
 * Self-checking bench for the parallel programming front end.
 * Assumes prog_model drives the programming pins; serial identification
 * port driven directly.
 */
`default_nettype none
module parallel_program_interface_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import parallel_program_pkg::*;

   logic       core_clk, rst_b, entry, load, act_lo, act_hi, sel, wr_b, oe_b;
   logic       doe, ready, f_ser, f_osc, p_one, p_two, oe, busy, tmo;
   logic [7:0] din, dout, sig_data, q;
   logic [1:0] sig_addr;
   logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
   int         failures = 0;
   int         n_tests = 0;

   parallel_program_interface uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .prog_entry_i(entry),
      .load_pulse_pin_i(load), .action_select_lo_i(act_lo), .action_select_hi_i(act_hi),
      .byte_half_select_i(sel), .write_strobe_b_i(wr_b), .output_strobe_b_i(oe_b), .data_i(din),
      .data_o(dout), .data_oe_o(doe), .prog_done_indicator_o(ready), .serial_sig_addr_i(sig_addr),
      .serial_sig_data_o(sig_data), .serial_download_fuse_o(f_ser), .internal_osc_fuse_o(f_osc),
      .protect_bit_one_o(p_one), .protect_bit_two_o(p_two));

   prog_model m (.core_clk_i(core_clk), .entry_o(entry), .load_o(load), .act_lo_o(act_lo),
      .act_hi_o(act_hi), .sel_o(sel), .wr_b_o(wr_b), .oe_b_o(oe_b), .data_o(din), .bus_i(dout),
      .bus_oe_i(doe), .ready_i(ready));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   function automatic logic [7:0] b(input logic x);
      return {7'h0, x};
   endfunction

   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wbyte(input logic s, input logic exp_busy);
      m.wr(s, busy, tmo);
      chk("busy seen", b(exp_busy), b(busy));
      if (tmo) begin
         failures++;
         $display("Error ready wait expected 1 seen timeout");
         wrap_up();
      end
   endtask

   task automatic rbyte(input string name, input logic s, input logic [7:0] exp);
      m.rd(s, q, oe);
      chk(name, exp, q);
      chk("bus driven", 8'h01, b(oe));
      chk("bus released", 8'h00, b(doe));
      chk("bus idle", 8'h00, dout);
   endtask

   task automatic addr(input logic [7:0] hi, input logic [7:0] lo);
      m.ld(ACT_ADDR, 1'b1, hi);
      m.ld(ACT_ADDR, 1'b0, lo);
   endtask

   initial begin
      rst_b = 1'b0;
      sig_addr = 2'h0;
      repeat (5) @(posedge core_clk);
      #1 rst_b = 1'b1;
      m.cyc(3);
      chk("serial fuse", 8'h00, b(f_ser));
      chk("osc fuse", 8'h01, b(f_osc));
      chk("protect", 8'h03, {6'h0, p_two, p_one});
      chk("ready", 8'h01, b(ready));
      m.enter();
      $display("Test reset done");
      m.ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
      wbyte(1'b0, 1'b0);
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_RD);
      addr(8'h01, 8'hA5);
      rbyte("erased lo", 1'b0, ERASED_BYTE);
      rbyte("erased hi", 1'b1, ERASED_BYTE);
      $display("Test erase done");
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_WR);
      addr(8'h01, 8'hA5);
      m.ld(ACT_DATA, 1'b0, 8'h34);
      wbyte(1'b0, 1'b1);
      m.ld(ACT_DATA, 1'b1, 8'h12);
      wbyte(1'b1, 1'b1);
      m.ld(ACT_ADDR, 1'b0, 8'hA6);
      m.ld(ACT_DATA, 1'b0, 8'h78);
      // High byte stays erased, so its FF write is skipped
      wbyte(1'b0, 1'b1);
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_RD);
      rbyte("next lo", 1'b0, 8'h78);
      rbyte("next hi", 1'b1, ERASED_BYTE);
      m.ld(ACT_ADDR, 1'b0, 8'hA5);
      rbyte("word lo", 1'b0, 8'h34);
      rbyte("word hi", 1'b1, 8'h12);
      m.ld(ACT_ADDR, 1'b1, 8'h00);
      rbyte("other page", 1'b0, ERASED_BYTE);
      $display("Test flash done");
      m.ld(ACT_CMD, 1'b0, CMD_EE_WR);
      m.ld(ACT_ADDR, 1'b0, 8'h05);
      m.ld(ACT_DATA, 1'b0, 8'h5C);
      wbyte(1'b0, 1'b1);
      m.ld(ACT_CMD, 1'b0, CMD_EE_RD);
      m.ld(2'h3, 1'b0, 8'h07);
      rbyte("eeprom", 1'b0, 8'h5C);
      $display("Test eeprom done");
      m.ld(ACT_CMD, 1'b0, CMD_SIG_RD);
      for (int i = 0; i < 3; i++) begin
         m.ld(ACT_ADDR, 1'b0, 8'(i));
         rbyte("sig", 1'b0, sig[i]);
         sig_addr = 2'(i);
         m.cyc(2);
         chk("serial sig", sig[i], sig_data);
      end
      $display("Test signature done");
      m.ld(ACT_CMD, 1'b0, CMD_FUSE_WR);
      m.ld(ACT_DATA, 1'b0, 8'hDE);
      wbyte(1'b0, 1'b0);
      chk("osc fuse", 8'h00, b(f_osc));
      chk("serial fuse", 8'h00, b(f_ser));
      m.ld(ACT_CMD, 1'b0, CMD_FUSE_RD);
      rbyte("fuse byte", 1'b0, 8'hDE);
      $display("Test fuse done");
      m.ld(ACT_CMD, 1'b0, CMD_PROT_WR);
      m.ld(ACT_DATA, 1'b0, 8'hFD);
      wbyte(1'b0, 1'b0);
      chk("protect", 8'h02, {6'h0, p_two, p_one});
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_WR);
      addr(8'h01, 8'hA5);
      m.ld(ACT_DATA, 1'b0, 8'h00);
      wbyte(1'b0, 1'b0);
      m.ld(ACT_CMD, 1'b0, CMD_FUSE_WR);
      m.ld(ACT_DATA, 1'b0, 8'hFF);
      wbyte(1'b0, 1'b0);
      chk("osc locked", 8'h00, b(f_osc));
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_RD);
      rbyte("mode 2 read", 1'b0, 8'h34);
      $display("Test mode 2 done");
      m.ld(ACT_CMD, 1'b0, CMD_PROT_WR);
      m.ld(ACT_DATA, 1'b0, 8'hF9);
      wbyte(1'b0, 1'b0);
      m.ld(ACT_DATA, 1'b0, 8'hFF);
      wbyte(1'b0, 1'b0);
      chk("protect", 8'h00, {6'h0, p_two, p_one});
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_RD);
      rbyte("mode 3 read", 1'b0, ERASED_BYTE);
      for (int i = 0; i < 3; i++) begin
         sig_addr = 2'(i);
         m.cyc(2);
         chk("serial sig locked", 8'(i), sig_data);
      end
      $display("Test mode 3 done");
      m.ld(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
      wbyte(1'b0, 1'b0);
      chk("protect", 8'h03, {6'h0, p_two, p_one});
      chk("osc kept", 8'h00, b(f_osc));
      m.ld(ACT_CMD, 1'b0, CMD_FLASH_RD);
      rbyte("erased again", 1'b1, ERASED_BYTE);
      $display("Test unlock done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ==== verification/prog_model.sv ====
/*
 * Behavioural parallel programmer: drives load, write and output strobes,
 * selects and the data bus towards the device, one step at a time.
 * Assumes the device synchronises strobes and acts three cycles after an edge.
 */
`default_nettype none
module prog_model (
   // Clock
   input  wire logic       core_clk_i,
   // Pins driven towards the device
   output logic            entry_o,
   output logic            load_o,
   output logic            act_lo_o,
   output logic            act_hi_o,
   output logic            sel_o,
   output logic            wr_b_o,
   output logic            oe_b_o,
   output logic      [7:0] data_o,
   // Pins seen from the device
   input  wire logic [7:0] bus_i,
   input  wire logic       bus_oe_i,
   input  wire logic       ready_i
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      entry_o = 1'b0;
      load_o = 1'b0;
      {act_hi_o, act_lo_o} = 2'h3;
      sel_o = 1'b0;
      wr_b_o = 1'b1;
      oe_b_o = 1'b1;
      data_o = 8'hA5;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   // Byte select held low across the entry rise
   task automatic enter();
      sel_o = 1'b0;
      cyc(20);
      entry_o = 1'b1;
      cyc(20);
   endtask

   task automatic ld(input logic [1:0] act, input logic sel, input logic [7:0] d);
      {act_hi_o, act_lo_o} = act;
      sel_o = sel;
      data_o = d;
      cyc(4);
      load_o = 1'b1;
      cyc(5);
      load_o = 1'b0;
      cyc(4);
      // Released bus must not keep showing the last byte
      data_o = ~d;
      {act_hi_o, act_lo_o} = 2'h3;
      // One edge before the next call may drive the selects again
      cyc(1);
   endtask

   // Waits for ready after busy, or past a full erase when no busy shows
   task automatic wr(input logic sel, output logic busy, output logic tmo);
      busy = 1'b0;
      tmo = 1'b1;
      sel_o = sel;
      cyc(4);
      wr_b_o = 1'b0;
      for (int i = 0; i < 600; i++) begin
         cyc(1);
         if (i == 8) wr_b_o = 1'b1;
         if (ready_i !== 1'b1) busy = 1'b1;
         if (i > 12 && ready_i === 1'b1 && (busy || i > 540)) begin
            tmo = 1'b0;
            break;
         end
      end
      cyc(4);
   endtask

   task automatic rd(input logic sel, output logic [7:0] q, output logic oe);
      sel_o = sel;
      cyc(4);
      oe_b_o = 1'b0;
      cyc(5);
      q = bus_i;
      oe = bus_oe_i;
      oe_b_o = 1'b1;
      cyc(4);
   endtask
endmodule
`default_nettype wire
